// File: hw/gdc_top.sv
`timescale 1ns/1ps
`include "gdc_cfg.svh"
module gdc_top #(
  parameter int SETUP_CYCLES = `GDC_SETUP_CYC
)(
  input  wire logic  i_sys_clk,
  input  wire logic  i_reset_n,
  input  wire logic  i_clk_en,
  input  wire logic  i_enable,
  input  wire logic  i_frame_select_n,
  input  wire logic  i_serial_clk,
  input  wire logic  i_serial_in,
  output logic       o_serial_out,
  output logic       o_serial_out_oe,
  output logic       o_standby,
  output logic       o_link_ready
);
  import gdc_pkg::*;

  // Storage index of each register.
  localparam gdc_idx_type IX_GC1     = 5'h00;
  localparam gdc_idx_type IX_GC2     = 5'h01;
  localparam gdc_idx_type IX_VDS     = 5'h02;
  localparam gdc_idx_type IX_CCP1    = 5'h03;
  localparam gdc_idx_type IX_CCP_ACT = 5'h04;
  localparam gdc_idx_type IX_CCP_FW  = 5'h05;
  localparam gdc_idx_type IX_HALF_BRIDGE_MODE_SELECT  = 5'h06;
  localparam gdc_idx_type IX_PULSE_CHANNEL_SETUP  = 5'h07;
  localparam gdc_idx_type IX_TPRE    = 5'h08;
  localparam gdc_idx_type IX_HBDIAG  = 5'h09;
  localparam gdc_idx_type IX_STATIC_BRIDGE_CHARGE_CURRENT = 5'h0A;
  localparam gdc_idx_type IX_PCHG_IN = 5'h0B;
  localparam gdc_idx_type IX_ICHG_A  = 5'h0C;
  localparam gdc_idx_type IX_ICHG_F  = 5'h0D;
  localparam gdc_idx_type IX_IDCHG_A = 5'h0E;
  localparam gdc_idx_type IX_PDCH_IN = 5'h0F;
  localparam gdc_idx_type IX_IMAX_A  = 5'h10;
  localparam gdc_idx_type IX_IMAX_F  = 5'h11;
  localparam gdc_idx_type IX_TDON1   = 5'h12;

  localparam logic [4:0]  BITS_FULL  = 5'(`GDC_FRAME_BITS);
  localparam logic [15:0] SETUP_LAST = 16'(SETUP_CYCLES - 1);

  // Reset release, pin synchronisers and edge history.
  logic rst_meta_ff;
  logic rst_n_ff;
  logic en_meta_ff;
  logic en_ff;
  logic cs_meta_ff;
  logic cs_ff;
  logic cs_d_ff;
  logic sck_meta_ff;
  logic sck_ff;
  logic sck_d_ff;
  logic sdi_meta_ff;
  logic sdi_ff;

  // Frame controller state.
  gdc_state_type state_ff;
  gdc_state_type nxt_state;
  logic [23:0]   rx_ff;
  logic [23:0]   nxt_rx;
  logic [23:0]   tx_ff;
  logic [23:0]   nxt_tx;
  logic [4:0]    cnt_ff;
  logic [4:0]    nxt_cnt;
  logic          err_ff;
  logic          nxt_err;
  logic          hit_ff;
  logic          nxt_hit;
  logic          ready_ff;
  logic          nxt_ready;
  logic [15:0]   setup_cnt_ff;
  logic [15:0]   nxt_setup_cnt;
  logic          standby_ff;

  gdc_reg_if rif ();

  gdc_reg_store u_store
  (
    .i_clk    (i_sys_clk),
    .i_rst_n  (rst_n_ff),
    .i_clk_en (i_clk_en),
    .bus      (rif)
  );

  // Reset is taken asynchronously and released through two flip-flops.
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Enable, select, clock and data each pass two flip-flops; select and clock also keep a third stage that the edge logic reads.
  always_ff @(posedge i_sys_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      en_meta_ff  <= 1'b0;
      en_ff       <= 1'b0;
      cs_meta_ff  <= 1'b1;
      cs_ff       <= 1'b1;
      cs_d_ff     <= 1'b1;
      sck_meta_ff <= 1'b0;
      sck_ff      <= 1'b0;
      sck_d_ff    <= 1'b0;
      sdi_meta_ff <= 1'b0;
      sdi_ff      <= 1'b0;
    end
    else if (i_clk_en)
    begin
      en_meta_ff  <= i_enable;
      en_ff       <= en_meta_ff;
      cs_meta_ff  <= i_frame_select_n;
      cs_ff       <= cs_meta_ff;
      cs_d_ff     <= cs_ff;
      sck_meta_ff <= i_serial_clk;
      sck_ff      <= sck_meta_ff;
      sck_d_ff    <= sck_ff;
      sdi_meta_ff <= i_serial_in;
      sdi_ff      <= sdi_meta_ff;
    end
  end

  // Edge events on the synchronised link signals.
  wire sck_rise = sck_ff & ~sck_d_ff;
  wire sck_fall = ~sck_ff & sck_d_ff;
  wire cs_fall  = ~cs_ff & cs_d_ff;
  wire cs_rise  = cs_ff & ~cs_d_ff;

  // Standby follows the enable pin; the setup counter restarts on every rise.
  always_comb
  begin
    nxt_setup_cnt = setup_cnt_ff;
    nxt_ready     = ready_ff;
    if (!en_ff)
    begin
      nxt_setup_cnt = 16'h0000;
      nxt_ready     = 1'b0;
    end
    else if (!ready_ff)
    begin
      if (setup_cnt_ff == SETUP_LAST)
        nxt_ready = 1'b1;
      else
        nxt_setup_cnt = setup_cnt_ff + 16'h0001;
    end
  end

  // Standby is reached three cycles after the pin falls, far inside the limit.
  always_ff @(posedge i_sys_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      standby_ff   <= 1'b1;
      ready_ff     <= 1'b0;
      setup_cnt_ff <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      standby_ff   <= ~en_ff;
      ready_ff     <= nxt_ready;
      setup_cnt_ff <= nxt_setup_cnt;
    end
  end

  // Fields of the received frame.
  wire        frm_wr   = rx_ff[`GDC_FRM_WR_BIT];
  wire [4:0]  frm_off  = rx_ff[`GDC_FRM_OFF_HI:`GDC_FRM_OFF_LO];
  wire [15:0] frm_data = rx_ff[15:0];
  wire        frm_full = (cnt_ff == BITS_FULL);

  // Offset and bank to storage index; a miss marks an empty slot.
  function automatic logic [5:0] decode(input logic [4:0] off, input logic bank);
    logic [5:0] r;
    r = {1'b1, IX_GC1};
    unique case (off)
      `GDC_OFF_GC1:    r = {1'b1, IX_GC1};
      `GDC_OFF_GC2:    r = {1'b1, IX_GC2};
      `GDC_OFF_VDS:    r = {1'b1, IX_VDS};
      `GDC_OFF_CCP1:   r = {1'b1, IX_CCP1};
      `GDC_OFF_CCP2:   r = {1'b1, bank ? IX_CCP_FW : IX_CCP_ACT};
      `GDC_OFF_HALF_BRIDGE_MODE_SELECT: r = {1'b1, IX_HALF_BRIDGE_MODE_SELECT};
      `GDC_OFF_PULSE_CHANNEL_SETUP: r = {~bank, IX_PULSE_CHANNEL_SETUP};
      `GDC_OFF_TPRE:   r = {1'b1, IX_TPRE};
      `GDC_OFF_HBDIAG: r = {1'b1, IX_HBDIAG};
      `GDC_OFF_ICHG_A: r = {1'b1, bank ? IX_PCHG_IN : IX_STATIC_BRIDGE_CHARGE_CURRENT};
      `GDC_OFF_ICHG_B: r = {1'b1, bank ? IX_ICHG_F : IX_ICHG_A};
      `GDC_OFF_IDCHG:  r = {1'b1, bank ? IX_PDCH_IN : IX_IDCHG_A};
      `GDC_OFF_IMAX:   r = {1'b1, bank ? IX_IMAX_F : IX_IMAX_A};
      `GDC_OFF_TDON1:  r = {1'b1, IX_TDON1};
      default:         r = {1'b0, IX_GC1};
    endcase
    return r;
  endfunction

  // Bank select feeds only this decode and never the stored words.
  wire [5:0]        dec     = decode(frm_off, rif.bank);
  wire              dec_hit = dec[5];
  wire gdc_idx_type dec_idx = dec[4:0];
  wire              frm_ok  = frm_full & ready_ff;

  // Store access: a write on commit of a good frame, and a read of the same slot.
  assign rif.wr_en   = (state_ff == ST_COMMIT) & frm_ok & frm_wr & dec_hit;
  assign rif.wr_idx  = dec_idx;
  assign rif.wr_data = frm_data;
  assign rif.rd_en   = (state_ff == ST_COMMIT);
  assign rif.rd_idx  = dec_idx;

  // Frame sequencing: shift on clock edges, commit and reload on frame end.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rx    = rx_ff;
    nxt_tx    = tx_ff;
    nxt_cnt   = cnt_ff;
    nxt_err   = err_ff;
    nxt_hit   = hit_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          nxt_cnt   = 5'h00;
          nxt_state = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        if (cs_rise)
          nxt_state = ST_COMMIT;
        else
        begin
          if (sck_rise)
          begin
            nxt_rx = {rx_ff[22:0], sdi_ff};
            if (cnt_ff != 5'h1F)
              nxt_cnt = cnt_ff + 5'h01;
          end
          if (sck_fall)
            nxt_tx = {tx_ff[22:0], 1'b0};
        end
      end
      ST_COMMIT:
      begin
        nxt_err   = ~frm_ok;
        nxt_hit   = dec_hit;
        nxt_state = ST_LOAD;
      end
      ST_LOAD:
      begin
        nxt_tx    = {8'h00, hit_ff ? rif.rd_data : 16'h0000};
        nxt_tx[`GDC_RESP_ERR_BIT] = err_ff;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Frame controller registers.
  always_ff @(posedge i_sys_clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      state_ff <= ST_IDLE;
      rx_ff    <= 24'h000000;
      tx_ff    <= 24'h000000;
      cnt_ff   <= 5'h00;
      err_ff   <= 1'b0;
      hit_ff   <= 1'b0;
    end
    else if (i_clk_en)
    begin
      state_ff <= nxt_state;
      rx_ff    <= nxt_rx;
      tx_ff    <= nxt_tx;
      cnt_ff   <= nxt_cnt;
      err_ff   <= nxt_err;
      hit_ff   <= nxt_hit;
    end
  end

  // Output drive follows the synchronised frame select, two edges at most.
  assign o_serial_out    = tx_ff[23];
  assign o_serial_out_oe = ~cs_ff;
  assign o_standby       = standby_ff;
  assign o_link_ready    = ready_ff;
endmodule

// File: hw/gdc_cfg.svh
// Summary of operation
// - Offset 0x05 picks active or freewheel cross-current settings by bank; reset 0x4924.
// - Offset 0x0A is static charge current (0x0044) or precharge init (0x18C6).
// - Offset 0x0B holds active or freewheel pulse charge current, both reset 0x18C6.
// - Offset 0x0D holds active or freewheel max current, both reset 0x4900.
// - Pulse channel setup at 0x07 exists only in bank 0; reset 0x6420.
// - Channel one switch delays at 0x0E exist in both banks; reset 0x0A0A.
// - General control first resets 0x0026, second resets 0x4180; both unbanked.
// - Bridge diagnostic current control at 0x09 in both banks; reset 0xC000.
// - Pulse precharge time at 0x08 in both banks; reset 0x0000.
// - Offset 0x04 resets 0x0000 and offset 0x02 resets 0x0249; both unbanked.
// - Standby is entered within 6 us after the enable input falls.
// - Serial output driven only while frame select low; switches within 50 ns.
// - Bank select is bit 9 of general control first; 0 selects active set.
`ifndef GDC_CFG_SVH
`define GDC_CFG_SVH

// Clock rate and link timing.
`define GDC_CLK_HZ          50000000
`define GDC_T_STANDBY_US    6
`define GDC_T_SETUP_US      150
`define GDC_T_CS_HIGH_US    3
`define GDC_T_SDO_NS        50
`define GDC_STANDBY_CYC     ((`GDC_T_STANDBY_US * (`GDC_CLK_HZ / 1000000)))
`define GDC_SETUP_CYC       ((`GDC_T_SETUP_US * (`GDC_CLK_HZ / 1000000)))

// Frame layout: 24 bits, write flag, 5-bit offset, 2 spare, 16 data.
`define GDC_FRAME_BITS      24
`define GDC_FRM_WR_BIT      23
`define GDC_FRM_OFF_HI      22
`define GDC_FRM_OFF_LO      18
`define GDC_RESP_ERR_BIT    23

// Documented register offsets.
`define GDC_OFF_GC1         5'h00
`define GDC_OFF_GC2         5'h01
`define GDC_OFF_VDS         5'h02
`define GDC_OFF_CCP1        5'h04
`define GDC_OFF_CCP2        5'h05
`define GDC_OFF_HALF_BRIDGE_MODE_SELECT      5'h06
`define GDC_OFF_PULSE_CHANNEL_SETUP      5'h07
`define GDC_OFF_TPRE        5'h08
`define GDC_OFF_HBDIAG      5'h09
`define GDC_OFF_ICHG_A      5'h0A
`define GDC_OFF_ICHG_B      5'h0B
`define GDC_OFF_IDCHG       5'h0C
`define GDC_OFF_IMAX        5'h0D
`define GDC_OFF_TDON1       5'h0E

// Bank select field position inside general control first.
`define GDC_BANK_BIT        9
// Bits of general control first that a write keeps; the cleared bits always read as zero.
`define GDC_GC1_WMASK       16'hFFAF

// Reset values in storage order, entry 0 in the low word.
`define GDC_NUM_REGS        19
`define GDC_RESET_VALS      {16'h0A0A, 16'h4900, 16'h4900, 16'h318C, 16'h1CE7, \
                             16'h18C6, 16'h18C6, 16'h18C6, 16'h0044, 16'hC000, \
                             16'h0000, 16'h6420, 16'h0000, 16'h4924, 16'h4924, \
                             16'h0000, 16'h0249, 16'h4180, 16'h0026}
`endif

// File: hw/gdc_pkg.sv
package gdc_pkg;
  // Storage index of one register in the register store.
  typedef logic [4:0] gdc_idx_type;
  // One register word.
  typedef logic [15:0] gdc_word_type;
  // Serial frame controller states.
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_COMMIT = 2'b10,
    ST_LOAD   = 2'b11
  } gdc_state_type;
endpackage

// File: hw/gdc_reg_if.sv
`timescale 1ns/1ps
interface gdc_reg_if;
  import gdc_pkg::*;
  logic         wr_en;
  gdc_idx_type  wr_idx;
  gdc_word_type wr_data;
  logic         rd_en;
  gdc_idx_type  rd_idx;
  gdc_word_type rd_data;
  logic         bank;
  modport ctrl
  (
    output wr_en, wr_idx, wr_data, rd_en, rd_idx,
    input  rd_data, bank
  );
  modport store
  (
    input  wr_en, wr_idx, wr_data, rd_en, rd_idx,
    output rd_data, bank
  );
endinterface

// File: hw/gdc_reg_store.sv
`timescale 1ns/1ps
`include "gdc_cfg.svh"
module gdc_reg_store #(
  parameter int                 NUM   = `GDC_NUM_REGS,
  parameter logic [NUM*16-1:0]  RVALS = `GDC_RESET_VALS
)(
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_clk_en,
  gdc_reg_if.store   bus
);
  import gdc_pkg::*;

  gdc_word_type regs_ff [NUM];
  gdc_word_type rd_data_ff;

  // Word as it will be stored; general control first drops its read-as-zero bits.
  wire gdc_word_type wr_word  = (bus.wr_idx == 5'h00) ? (bus.wr_data & `GDC_GC1_WMASK)
                                                      : bus.wr_data;
  // A read of the slot being written in the same cycle returns the new word.
  wire               rd_bypass = bus.wr_en && (bus.wr_idx == bus.rd_idx);

  // One storage word per register, each with its own reset value.
  genvar g;
  generate
    for (g = 0; g < NUM; g++)
    begin : g_reg
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
          regs_ff[g] <= RVALS[g*16 +: 16];
        else if (i_clk_en && bus.wr_en && (bus.wr_idx == 5'(g)))
          regs_ff[g] <= wr_word;
      end
    end
  endgenerate

  // Read data comes out of a register one cycle after the request.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rd_data_ff <= 16'h0000;
    else if (i_clk_en && bus.rd_en)
      rd_data_ff <= rd_bypass ? wr_word : regs_ff[bus.rd_idx];
  end

  assign bus.rd_data = rd_data_ff;
  // Bank select lives in general control first; it steers decode only.
  assign bus.bank    = regs_ff[0][`GDC_BANK_BIT];
endmodule

// File: dv/gdc_host_model.sv
`timescale 1ns/1ps
module gdc_host_model
(
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  // Idle pins sit at their pull levels: select high, clock and data low.
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b0;
  end
  // One frame of n bits, MSB first; the reply is sampled on each rising clock.
  task automatic xfer(input logic [23:0] d, input int n, output logic [23:0] r);
    r = 24'h000000;
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      o_sdi = d[23-i];
      #80 o_sclk = 1'b1;
      r = {r[22:0], i_sdo_oe ? i_sdo : 1'bz};
      #80 o_sclk = 1'b0;
    end
    // A short frame still returns the reply aligned to the top bit.
    r = r << (24 - n);
    #80 o_cs_n = 1'b1;
    o_sdi = 1'b0;
    #3000;
  endtask
endmodule

// File: dv/gdc_top_monitor.sv
`timescale 1ns/1ps
module gdc_top_monitor #(
  parameter int SETUP_CYCLES = 7500
)(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_enable,
  input wire logic i_frame_select_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_in,
  input wire logic o_serial_out,
  input wire logic o_serial_out_oe,
  input wire logic o_standby,
  input wire logic o_link_ready
);
  int en_cnt_ff;
  int nxt_en_cnt;
  // Counts cycles of enable held high, so the setup wait can be bounded.
  assign nxt_en_cnt = i_enable ? en_cnt_ff + 1 : 0;
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
    if (!i_reset_n) en_cnt_ff <= 0;
    else en_cnt_ff <= nxt_en_cnt;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  a_oe_idle_off: assert property (i_frame_select_n [*4] |-> !o_serial_out_oe)
    else $error("serial output driven outside a frame");
  a_oe_frame_on: assert property (!i_frame_select_n [*4] |-> o_serial_out_oe)
    else $error("serial output not driven inside a frame");
  a_sdo_steady: assert property ((o_serial_out_oe && i_serial_clk) [*4] |-> $stable(o_serial_out))
    else $error("serial output moved while clock high");
  a_standby_entry: assert property ($fell(i_enable) |-> ##[1:4] o_standby)
    else $error("standby late after enable fall");
  a_standby_hold: assert property (!i_enable [*8] |-> o_standby)
    else $error("standby lost while enable low");
  a_standby_exit: assert property (i_enable [*8] |-> !o_standby)
    else $error("standby held while enable high");
  a_ready_min: assert property ($rose(o_link_ready) |-> en_cnt_ff >= SETUP_CYCLES)
    else $error("link ready before setup time");
  a_ready_bound: assert property (en_cnt_ff > SETUP_CYCLES + 10 |-> o_link_ready)
    else $error("link ready late");
  a_ready_drop: assert property ($fell(i_enable) |-> ##[1:4] !o_link_ready)
    else $error("link ready kept after enable fall");
  c_frame: cover property ($rose(i_frame_select_n));
  c_standby: cover property ($rose(o_standby));
  c_ready: cover property ($rose(o_link_ready));
endmodule
bind gdc_top gdc_top_monitor #(.SETUP_CYCLES(SETUP_CYCLES)) mon
(
  .i_sys_clk, .i_reset_n, .i_clk_en, .i_enable, .i_frame_select_n, .i_serial_clk,
  .i_serial_in, .o_serial_out, .o_serial_out_oe, .o_standby, .o_link_ready
);

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
`define WAITC(c, n) for (k = 0; k < (n) && !(c); k++) @(posedge sys_clk); \
  if (!(c)) begin fail_count++; tally_and_finish; end
module tb_top;
  localparam int SETUP = 500;
  localparam logic [15:0] RB0 [15] = '{16'h0026, 16'h4180, 16'h0249, 16'h0000, 16'h0000,
    16'h4924, 16'h0000, 16'h6420, 16'h0000, 16'hC000, 16'h0044, 16'h18C6, 16'h1CE7,
    16'h4900, 16'h0A0A};
  localparam logic [15:0] RB1 [15] = '{16'h0226, 16'h4180, 16'h0249, 16'h0000, 16'h0000,
    16'h4924, 16'h0000, 16'h0000, 16'h0000, 16'hC000, 16'h18C6, 16'h18C6, 16'h318C,
    16'h4900, 16'h0A0A};
  localparam logic [4:0] BK [6] = '{5'h05, 5'h07, 5'h0A, 5'h0B, 5'h0C, 5'h0D};
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        enable  = 1'b1;
  logic [23:0] pend    = 24'h000000;
  logic [23:0] pmsk    = 24'h000000;
  logic [23:0] rx;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          k;
  wire         cs_n, sclk, sdi, serial_out, sdo_oe, standby, ready;
  // Free-running system clock.
  always #10 sys_clk = ~sys_clk;
  gdc_top #(.SETUP_CYCLES(SETUP)) dut
  (
    .i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_clk_en(1'b1), .i_enable(enable),
    .i_frame_select_n(cs_n), .i_serial_clk(sclk), .i_serial_in(sdi), .o_serial_out(serial_out),
    .o_serial_out_oe(sdo_oe), .o_standby(standby), .o_link_ready(ready)
  );
  gdc_host_model host
  (
    .i_sdo(serial_out), .i_sdo_oe(sdo_oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi)
  );
  // Distinct data per bank and offset so crossed banks show up.
  function automatic logic [15:0] wv(input logic b, input logic [4:0] a);
    return {b ? 8'hA5 : 8'h5A, 3'b000, a};
  endfunction
  // Sends a frame, checks the reply owed by the previous one, records this one's.
  task automatic op(input logic w, input logic [4:0] a, input logic [15:0] d,
                    input logic [15:0] e, input int n = 24);
    host.xfer({w, a, 2'b00, d}, n, rx);
    `CHK(rx & pmsk, pend & pmsk)
    pend = {8'h00, e};
    pmsk = 24'hFFFFFF;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset_vals;
    for (int i = 0; i < 15; i++) op(0, 5'(i), 16'h0000, RB0[i]);
    $display("bank 0 reset values done");
  endtask
  task automatic t_bank1;
    op(1, 5'h00, 16'h0226, 16'h0226);
    for (int i = 1; i < 15; i++) op(0, 5'(i), 16'h0000, RB1[i]);
    $display("bank 1 reset values done");
  endtask
  task automatic t_banks;
    foreach (BK[i]) op(1, BK[i], wv(1, BK[i]), BK[i] == 5'h07 ? 16'h0000 : wv(1, BK[i]));
    op(1, 5'h00, 16'h0026, 16'h0026);
    foreach (BK[i]) op(0, BK[i], 16'h0000, RB0[BK[i]]);
    foreach (BK[i]) op(1, BK[i], wv(0, BK[i]), wv(0, BK[i]));
    op(1, 5'h00, 16'h0226, 16'h0226);
    foreach (BK[i]) op(0, BK[i], 16'h0000, BK[i] == 5'h07 ? 16'h0000 : wv(1, BK[i]));
    $display("bank isolation done");
  endtask
  task automatic t_unmapped;
    op(1, 5'h03, 16'hFFFF, 16'h0000);
    op(1, 5'h0F, 16'hFFFF, 16'h0000);
    op(1, 5'h00, 16'h0050, 16'h0000);
    op(0, 5'h02, 16'h0000, 16'h0249);
    op(0, 5'h0E, 16'h0000, 16'h0A0A);
    op(0, 5'h09, 16'h0000, 16'hC000);
    $display("unmapped offsets done");
  endtask
  task automatic t_bad_len;
    op(1, 5'h04, 16'h1234, 16'h0000, 23);
    pend = 24'h800000;
    pmsk = 24'h800000;
    op(0, 5'h04, 16'h0000, 16'h0000);
    op(0, 5'h08, 16'h0000, 16'h0000);
    $display("short frame done");
  endtask
  task automatic t_standby;
    @(posedge sys_clk);
    enable <= 1'b0;
    `WAITC(standby === 1'b1, 300)
    `CHK(ready, 1'b0)
    @(posedge sys_clk);
    enable <= 1'b1;
    pmsk = 24'h000000;
    op(1, 5'h05, 16'h7777, 16'h0000);
    pend = 24'h800000;
    pmsk = 24'h800000;
    `WAITC(ready === 1'b1, SETUP + 20)
    op(0, 5'h05, 16'h0000, wv(0, 5'h05));
    op(0, 5'h00, 16'h0000, 16'h0000);
    $display("standby and setup done");
  endtask
  // Main sequence: reset, wait for the link, then each scenario in turn.
  initial
  begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    `WAITC(ready === 1'b1, SETUP + 20)
    t_reset_vals;
    t_bank1;
    t_banks;
    t_unmapped;
    t_bad_len;
    t_standby;
    tally_and_finish;
  end
endmodule
